// ===== bench/swk_far_end.sv
/*
 * far-side model: gpio pins, resume detector and timer line, set on command.
 * assumes commands change right after a rising edge of clk.
 */
`timescale 1ns/1ns
module swk_far_end (
	clk, // register clock
	nrst, // async reset, active low
	gpio_cmd, // wanted pin levels
	resume_cmd, // wanted resume level
	timer_cmd, // wanted timer level
	gpio_in, // pins seen by the block
	resume_in, // resume level seen by the block
	timer_irq_in // timer level seen by the block
);
	input wire logic clk;
	input wire logic nrst;
	input wire logic [31:0] gpio_cmd;
	input wire logic resume_cmd;
	input wire logic timer_cmd;
	output logic [31:0] gpio_in;
	output logic resume_in;
	output logic timer_irq_in;
	// lines move on the falling edge so they are asynchronous to the sampling edge
	always_ff @(negedge clk or negedge nrst) begin
		if (!nrst) begin
			gpio_in <= 32'h0000_0000;
			resume_in <= 1'b0;
			timer_irq_in <= 1'b0;
		end else begin
			gpio_in <= gpio_cmd;
			resume_in <= resume_cmd;
			timer_irq_in <= timer_cmd;
		end
	end
endmodule : swk_far_end

// ===== bench/testbench.sv
/*
 * self-checking bench for the wake-up source logic: register port, events, power.
 * assumes the 250 MHz clock and the far-side model beside the block.
 */
`timescale 1ns/1ns
module testbench;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [11:0] addr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [31:0] gpio_cmd = 32'h0000_0000;
	logic resume_cmd = 1'b0;
	logic timer_cmd = 1'b0;
	logic [31:0] gpio_in;
	logic resume_in;
	logic timer_irq_in;
	logic [31:0] gpio_level;
	logic wake_req;
	logic osc_restart;
	logic [1:0] power_state;
	logic irq;
	int failures = 0;
	int checks_done = 0;
	int seed = 32'hf9ad;
	int ln;
	int n;
	logic [31:0] v = 32'h0000_0000;
	logic [31:0] d;
	logic [31:0] b;
	logic rm;
	logic fm;
	logic e;
	always #2 clk = ~clk;
	swk_far_end u_far (.clk(clk), .nrst(nrst), .gpio_cmd(gpio_cmd), .resume_cmd(resume_cmd),
		.timer_cmd(timer_cmd), .gpio_in(gpio_in), .resume_in(resume_in),
		.timer_irq_in(timer_irq_in));
	swk_wake_src u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .gpio_in(gpio_in), .resume_in(resume_in), .timer_irq_in(timer_irq_in),
		.gpio_level(gpio_level), .wake_req(wake_req), .osc_restart(osc_restart),
		.power_state(power_state), .irq(irq));
	function automatic logic [31:0] exp_status(input logic t, input logic g, input logic r);
		return {28'h0, r, g, 1'b0, t};
	endfunction : exp_status
	task automatic give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checks_done++;
		if (got !== ex) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		// look just after the edge so registered and combinational outputs have settled
		#1;
	endtask : cyc
	task automatic wreg(input logic [11:0] a, input logic [31:0] x);
		@(posedge clk);
		addr <= a;
		wdata <= x;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [11:0] a, output logic [31:0] x);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 x = rdata;
	endtask : rreg
	task automatic creg(input logic [11:0] a, input logic [31:0] ex, input string nm);
		logic [31:0] x;
		rreg(a, x);
		chk(nm, ex, x);
	endtask : creg
	initial begin
		#80000;
		failures++;
		$display("Error watchdog expected finish seen hang");
		give_verdict();
	end
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		creg(swk_pkg::STATUS_OFS, 32'h0, "status reset");
		creg(swk_pkg::MASK_OFS, 32'hff, "mask reset");
		creg(swk_pkg::GPIO_FLAGS_OFS, 32'h0, "flags reset");
		creg(12'h7f0, 32'h0, "unmapped read");
		wreg(swk_pkg::MASK_OFS, 32'h0);
		creg(swk_pkg::MASK_OFS, 32'hf2, "mask fixed ones");
		wreg(swk_pkg::IRQ_MASK_OFS, 32'h0);
		$display("test reset done");
		timer_cmd <= 1'b1;
		resume_cmd <= 1'b1;
		cyc(6);
		creg(swk_pkg::STATUS_OFS, exp_status(1'b1, 1'b0, 1'b1), "status events");
		chk("irq", 32'h1, irq);
		chk("wake", 32'h1, wake_req);
		wreg(swk_pkg::STATUS_OFS, 32'hffff_fff6);
		creg(swk_pkg::STATUS_OFS, exp_status(1'b1, 1'b0, 1'b1), "write zero keeps");
		wreg(swk_pkg::STATUS_OFS, 32'h1);
		creg(swk_pkg::STATUS_OFS, exp_status(1'b0, 1'b0, 1'b1), "clear timer");
		wreg(swk_pkg::MASK_OFS, 32'h08);
		cyc(1);
		chk("masked wake", 32'h0, wake_req);
		chk("masked irq", 32'h0, irq);
		timer_cmd <= 1'b0;
		resume_cmd <= 1'b0;
		wreg(swk_pkg::STATUS_OFS, 32'h8);
		creg(swk_pkg::STATUS_OFS, 32'h0, "clear resume");
		wreg(swk_pkg::MASK_OFS, 32'h0);
		$display("test status done");
		for (int i = 0; i < 6; i++) begin
			ln = $unsigned($random(seed)) % 32;
			b = 32'h1 << ln;
			rm = (i == 0) ? 1'b1 : $random(seed);
			fm = (i == 0) ? 1'b1 : $random(seed);
			wreg(swk_pkg::RISE_MASK_OFS, rm ? 32'hffff_ffff : ~b);
			wreg(swk_pkg::FALL_MASK_OFS, fm ? 32'hffff_ffff : ~b);
			v = v ^ b;
			gpio_cmd <= v;
			e = v[ln] ? !rm : !fm;
			cyc(6);
			creg(swk_pkg::GPIO_FLAGS_OFS, e ? b : 32'h0, "edge flag");
			creg(swk_pkg::STATUS_OFS, exp_status(1'b0, e, 1'b0), "gpio summary");
			chk("gpio level", {31'h0, v[ln]}, {31'h0, gpio_level[ln]});
			wreg(swk_pkg::GPIO_FLAGS_OFS, b);
			creg(swk_pkg::STATUS_OFS, 32'h0, "summary clear");
			wreg(swk_pkg::RISE_MASK_OFS, ~b);
			wreg(swk_pkg::FALL_MASK_OFS, ~b);
			v = v ^ b;
			gpio_cmd <= v;
			cyc(6);
			creg(swk_pkg::GPIO_FLAGS_OFS, b, "re-armed flag");
			wreg(swk_pkg::GPIO_FLAGS_OFS, b);
		end
		$display("test gpio done");
		wreg(swk_pkg::RISE_MASK_OFS, 32'hffff_ffff);
		wreg(swk_pkg::FALL_MASK_OFS, 32'hffff_ffff);
		v[0] = 1'b0;
		gpio_cmd <= v;
		cyc(6);
		wreg(swk_pkg::GPIO_FLAGS_OFS, 32'hffff_ffff);
		wreg(swk_pkg::RISE_MASK_OFS, 32'hffff_fffe);
		wreg(swk_pkg::POWER_CTRL_OFS, 32'h3);
		cyc(50);
		rreg(swk_pkg::STATUS_OFS, d);
		chk("busy", 32'h1, {31'h0, d[1]});
		n = 0;
		// firmware side: poll busy until it drops, with a bound
		do begin
			rreg(swk_pkg::STATUS_OFS, d);
			n++;
		end while (d[1] !== 1'b0 && n < 100);
		chk("busy end", 32'h0, {31'h0, d[1]});
		chk("state p3", 32'h3, {30'h0, power_state});
		timer_cmd <= 1'b1;
		cyc(6);
		chk("timer no wake", 32'h0, wake_req);
		v[0] = 1'b1;
		gpio_cmd <= v;
		cyc(8);
		chk("gpio wake", 32'h1, wake_req);
		chk("state p1", 32'h1, {30'h0, power_state});
		chk("osc idle", 32'h0, osc_restart);
		wreg(swk_pkg::MASK_OFS, 32'hff);
		wreg(swk_pkg::POWER_CTRL_OFS, 32'h2);
		cyc(1);
		chk("state p2", 32'h2, {30'h0, power_state});
		chk("p2 masked wake", 32'h0, wake_req);
		wreg(swk_pkg::MASK_OFS, 32'h0);
		#1;
		chk("osc restart", 32'h1, osc_restart);
		cyc(1);
		chk("p2 to p1", 32'h1, {30'h0, power_state});
		$display("test power done");
		give_verdict();
	end
endmodule : testbench

// ===== hw/swk_edge_cap.sv
/*
 * one gpio edge catcher: synchroniser, per-direction enable, sticky flag.
 * assumes the line is asynchronous to clk.
 */
`timescale 1ns/1ns
module swk_edge_cap (
	input wire logic clk, // register clock
	input wire logic nrst, // async reset, active low
	input wire logic pin, // raw gpio line
	input wire logic rise_mask, // 1 blocks rising edges
	input wire logic fall_mask, // 1 blocks falling edges
	input wire logic clr, // write-one clear
	output logic flag, // sticky edge flag
	output logic level // synchronised level
);
	logic meta_r;
	logic sync_r;
	logic prev_r;
	logic flag_r;
	logic set_ev;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign set_ev = (sync_r & ~prev_r & ~rise_mask) | (~sync_r & prev_r & ~fall_mask); // RULE2 RULE15

	// set beats clear so an edge landing on the clear cycle re-arms the flag
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flag_r <= 1'b0;
		end else if (set_ev) begin
			flag_r <= 1'b1; // RULE12 RULE19
		end else if (clr) begin
			flag_r <= 1'b0; // RULE13
		end
	end

	assign flag = flag_r;
	assign level = sync_r;

	both_masked_a: assert property (@(posedge clk) disable iff (!nrst) // RULE15
		(rise_mask && fall_mask && !flag_r) |=> !flag_r)
		else $error("flag set with both directions masked");
endmodule : swk_edge_cap

// ===== hw/swk_pkg.sv
/*
 * constants for the suspend wake-up source logic: register offsets, field
 * positions and reset values. assumes a 32-bit register port with byte addresses.
 */
package swk_pkg;
	localparam logic [11:0] STATUS_OFS = 12'h408;
	localparam logic [11:0] MASK_OFS = 12'h40c;
	localparam logic [11:0] GPIO_FLAGS_OFS = 12'h410;
	localparam logic [11:0] FALL_MASK_OFS = 12'h414;
	localparam logic [11:0] RISE_MASK_OFS = 12'h418;
	localparam logic [11:0] POWER_CTRL_OFS = 12'h41c;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h424;
	localparam int TIMER_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int GPIO_BIT = 2;
	localparam int RESUME_BIT = 3;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] MASK_FIXED_ONES = 8'hf2;
	localparam logic [31:0] GPIO_FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] DIR_MASK_RST = 32'hffff_ffff;
	localparam logic [3:0] IRQ_MASK_RST = 4'hf;
	// shutdown time of pll and ring oscillator, in ns
	localparam int SHUTDOWN_NS = 400;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SHUTDOWN_CYC = (SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		SWK_P0 = 2'b00,
		SWK_P1 = 2'b01,
		SWK_P2 = 2'b10,
		SWK_P3 = 2'b11
	} swk_pstate_t;
endpackage : swk_pkg

// ===== hw/swk_wake_src.sv
/*
 * suspend wake-up source logic: status, mask, gpio edge flags, direction
 * masks, power-state tracking, shutdown busy and one level interrupt.
 * assumes a single-cycle register port; resume and timer events are levels
 * from other domains and pass two flip-flops here.
 */
// Strobed register access was decided locally.
// Summary of operation
// RULE1: in full suspend only unmasked gpio or resume events wake the device.
// RULE2: rising and falling gpio edges both detected, each direction masked separately.
// RULE3: direction masks touch only wake generation, not normal gpio interrupts.
// RULE4: timer interrupt sets bit 0 of status.
// RULE5: global resume detected sets bit 3 of status.
// RULE6: bit 2 is read-only, set while any unmasked gpio flag is set.
// RULE7: busy bit 1 high while pll and ring oscillator shut down.
// RULE8: busy never interrupts or wakes; its mask bit reads one.
// RULE9: writing one clears a status flag, zero leaves it.
// RULE10: any unmasked set source restarts processor clock and oscillators.
// RULE11: mask resets to ones; bits 3,2,0 gate sources; bits 7:4 read one.
// RULE12: 32 gpio edge flags, reset to zero, set on level change.
// RULE13: writing one clears a gpio flag and re-arms detection.
// RULE14: any set unmasked gpio flag forces status bit 2.
// RULE15: only unmasked directions set a flag; both masked never sets.
// RULE16: status bits 7:4 read zero; status resets to zero.
// RULE17: wake in full suspend restarts clocks into pll-running gated state.
// RULE18: wake request is OR of flag and not mask; capture needs no clock. Here the flags are captured on clk.
// RULE19: inputs synchronised first; set wins over a same-cycle clear.
`timescale 1ns/1ns
module swk_wake_src #(
	parameter int GPIO_N = 32 // number of gpio lines
) (
	input wire logic clk, // 250 MHz register clock
	input wire logic nrst, // async reset, active low
	input wire logic [11:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [31:0] rdata, // read data, cycle after rd
	input wire logic [GPIO_N-1:0] gpio_in, // gpio pins
	input wire logic resume_in, // global resume detected, level
	input wire logic timer_irq_in, // timer interrupt, level
	output logic [GPIO_N-1:0] gpio_level, // synchronised gpio to normal irq path
	output logic wake_req, // restart processor clock and oscillators
	output logic osc_restart, // restart ring and crystal oscillators
	output logic [1:0] power_state, // current power state
	output logic irq // level interrupt
);
	logic [7:0] status_r;
	logic [7:0] mask_r;
	logic [GPIO_N-1:0] fall_mask_r;
	logic [GPIO_N-1:0] rise_mask_r;
	logic [GPIO_N-1:0] gpio_flags;
	logic [GPIO_N-1:0] gpio_clr;
	logic [3:0] irq_mask_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic res_meta_r, res_sync_r, res_prev_r;
	logic tmr_meta_r, tmr_sync_r, tmr_prev_r;
	logic resume_ev, timer_ev, gpio_any;
	logic status_wr, shutdown_req;
	logic [15:0] busy_cnt_r;
	logic busy;
	logic any_unmasked;
	logic [7:0] status_view;
	logic [7:0] mask_view;
	swk_pkg::swk_pstate_t pstate_r;
	swk_pkg::swk_pstate_t pstate_nxt;

	// edge catchers, one per line; direction masks feed only these, never gpio_level
	genvar g;
	generate
		for (g = 0; g < GPIO_N; g++) begin : g_line
			swk_edge_cap u_cap (
				.clk(clk),
				.nrst(nrst),
				.pin(gpio_in[g]),
				.rise_mask(rise_mask_r[g]),
				.fall_mask(fall_mask_r[g]),
				.clr(gpio_clr[g]),
				.flag(gpio_flags[g]),
				.level(gpio_level[g]) // RULE3
			);
		end
	endgenerate

	assign gpio_clr = (wr && addr == swk_pkg::GPIO_FLAGS_OFS) ? wdata[GPIO_N-1:0] : '0; // RULE13

	// flags latch in the clocked domain; a fully clockless catch needs a pad cell
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_meta_r <= 1'b0;
			res_sync_r <= 1'b0;
			res_prev_r <= 1'b0;
			tmr_meta_r <= 1'b0;
			tmr_sync_r <= 1'b0;
			tmr_prev_r <= 1'b0;
		end else begin
			res_meta_r <= resume_in; // RULE19
			res_sync_r <= res_meta_r;
			res_prev_r <= res_sync_r;
			tmr_meta_r <= timer_irq_in;
			tmr_sync_r <= tmr_meta_r;
			tmr_prev_r <= tmr_sync_r;
		end
	end

	assign resume_ev = res_sync_r & ~res_prev_r;
	assign timer_ev = tmr_sync_r & ~tmr_prev_r;
	assign gpio_any = |gpio_flags; // RULE14
	assign status_wr = wr && addr == swk_pkg::STATUS_OFS;

	// bit 2 is not stored: it follows the gpio flags directly
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= swk_pkg::STATUS_RST; // RULE16
		end else begin
			if (timer_ev) begin
				status_r[swk_pkg::TIMER_BIT] <= 1'b1; // RULE4 RULE19
			end else if (status_wr && wdata[swk_pkg::TIMER_BIT]) begin
				status_r[swk_pkg::TIMER_BIT] <= 1'b0; // RULE9
			end
			if (resume_ev) begin
				status_r[swk_pkg::RESUME_BIT] <= 1'b1; // RULE5 RULE19
			end else if (status_wr && wdata[swk_pkg::RESUME_BIT]) begin
				status_r[swk_pkg::RESUME_BIT] <= 1'b0; // RULE9
			end
		end
	end

	assign status_view = {4'h0, status_r[swk_pkg::RESUME_BIT], gpio_any, busy,
		status_r[swk_pkg::TIMER_BIT]}; // RULE6 RULE16

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mask_r <= swk_pkg::MASK_RST; // RULE11
		end else if (wr && addr == swk_pkg::MASK_OFS) begin
			mask_r <= wdata[7:0] | swk_pkg::MASK_FIXED_ONES; // RULE8 RULE11
		end
	end

	assign mask_view = mask_r | swk_pkg::MASK_FIXED_ONES;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fall_mask_r <= swk_pkg::DIR_MASK_RST[GPIO_N-1:0];
			rise_mask_r <= swk_pkg::DIR_MASK_RST[GPIO_N-1:0];
		end else begin
			if (wr && addr == swk_pkg::FALL_MASK_OFS) begin
				fall_mask_r <= wdata[GPIO_N-1:0]; // RULE2
			end
			if (wr && addr == swk_pkg::RISE_MASK_OFS) begin
				rise_mask_r <= wdata[GPIO_N-1:0]; // RULE2
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_mask_r <= swk_pkg::IRQ_MASK_RST;
		end else if (wr && addr == swk_pkg::IRQ_MASK_OFS) begin
			irq_mask_r <= wdata[3:0];
		end
	end

	// busy is left out of the wake OR on purpose
	assign any_unmasked = (status_r[swk_pkg::TIMER_BIT] & ~mask_r[swk_pkg::TIMER_BIT])
		| (gpio_any & ~mask_r[swk_pkg::GPIO_BIT])
		| (status_r[swk_pkg::RESUME_BIT] & ~mask_r[swk_pkg::RESUME_BIT]); // RULE8 RULE18

	// in full suspend the timer is not clocked, so only gpio and resume count
	always_comb begin
		if (pstate_r == swk_pkg::SWK_P3) begin
			wake_req = (gpio_any & ~mask_r[swk_pkg::GPIO_BIT])
				| (status_r[swk_pkg::RESUME_BIT] & ~mask_r[swk_pkg::RESUME_BIT]); // RULE1
		end else begin
			wake_req = any_unmasked; // RULE10
		end
	end

	assign osc_restart = wake_req && (pstate_r == swk_pkg::SWK_P3 || pstate_r == swk_pkg::SWK_P2); // RULE10

	assign shutdown_req = wr && addr == swk_pkg::POWER_CTRL_OFS && wdata[1];

	// firmware requests a power state; wake events pull p2/p3 back to p1
	always_comb begin
		pstate_nxt = pstate_r;
		case (pstate_r)
			swk_pkg::SWK_P0, swk_pkg::SWK_P1: begin
				if (wr && addr == swk_pkg::POWER_CTRL_OFS) begin
					pstate_nxt = swk_pkg::swk_pstate_t'(wdata[1:0]);
				end
			end
			swk_pkg::SWK_P2, swk_pkg::SWK_P3: begin
				if (wake_req) begin
					pstate_nxt = swk_pkg::SWK_P1; // RULE17
				end
			end
			default: pstate_nxt = swk_pkg::SWK_P0;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pstate_r <= swk_pkg::SWK_P0;
		end else begin
			pstate_r <= pstate_nxt;
		end
	end

	assign power_state = pstate_r;

	// busy covers the pll and ring oscillator shutdown window
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_cnt_r <= 16'h0000;
		end else if (shutdown_req && pstate_r != swk_pkg::SWK_P2 && pstate_r != swk_pkg::SWK_P3) begin
			busy_cnt_r <= 16'(swk_pkg::SHUTDOWN_CYC); // RULE7
		end else if (busy_cnt_r != 16'h0000) begin
			busy_cnt_r <= busy_cnt_r - 16'h0001;
		end
	end

	assign busy = busy_cnt_r != 16'h0000; // RULE7

	assign irq = |({status_r[swk_pkg::RESUME_BIT], gpio_any, status_r[swk_pkg::TIMER_BIT]}
		& ~{mask_r[swk_pkg::RESUME_BIT], mask_r[swk_pkg::GPIO_BIT], mask_r[swk_pkg::TIMER_BIT]}
		& ~{irq_mask_r[3], irq_mask_r[2], irq_mask_r[0]}); // RULE8

	always_comb begin
		case (addr)
			swk_pkg::STATUS_OFS: rdata_nxt = {24'h0, status_view};
			swk_pkg::MASK_OFS: rdata_nxt = {24'h0, mask_view};
			swk_pkg::GPIO_FLAGS_OFS: rdata_nxt = 32'(gpio_flags);
			swk_pkg::FALL_MASK_OFS: rdata_nxt = 32'(fall_mask_r);
			swk_pkg::RISE_MASK_OFS: rdata_nxt = 32'(rise_mask_r);
			swk_pkg::POWER_CTRL_OFS: rdata_nxt = {30'h0, pstate_r};
			swk_pkg::IRQ_MASK_OFS: rdata_nxt = {28'h0, irq_mask_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= 32'h0000_0000;
		end else if (rd) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h0000_0000;
		end
	end

	assign rdata = rdata_r;

	// per-source set and write-one clear
	resume_set_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
		resume_ev |=> status_r[swk_pkg::RESUME_BIT])
		else $error("resume event did not set status");
	timer_set_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
		timer_ev |=> status_r[swk_pkg::TIMER_BIT])
		else $error("timer event did not set status");
	w1c_clear_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		(status_wr && wdata[swk_pkg::RESUME_BIT] && !resume_ev)
		|=> !status_r[swk_pkg::RESUME_BIT])
		else $error("write one did not clear resume");
	timer_clear_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		(status_wr && wdata[swk_pkg::TIMER_BIT] && !timer_ev)
		|=> !status_r[swk_pkg::TIMER_BIT])
		else $error("write one did not clear timer");
	zero_keeps_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		(status_wr && !wdata[swk_pkg::TIMER_BIT] && status_r[swk_pkg::TIMER_BIT])
		|=> status_r[swk_pkg::TIMER_BIT])
		else $error("write zero changed timer flag");
	resume_keep_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
		(status_r[swk_pkg::RESUME_BIT] && !(status_wr && wdata[swk_pkg::RESUME_BIT]))
		|=> status_r[swk_pkg::RESUME_BIT])
		else $error("resume flag dropped without a clear");
	set_wins_a: assert property (@(posedge clk) disable iff (!nrst) // RULE19
		(resume_ev && status_wr && wdata[swk_pkg::RESUME_BIT])
		|=> status_r[swk_pkg::RESUME_BIT])
		else $error("clear beat a same-cycle resume event");

	// register views and writes
	mask_fixed_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
		mask_view[7:4] == 4'hf && mask_view[swk_pkg::BUSY_BIT])
		else $error("fixed mask bits not one");
	mask_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
		(wr && addr == swk_pkg::MASK_OFS)
		|=> mask_view == ($past(wdata[7:0]) | swk_pkg::MASK_FIXED_ONES))
		else $error("mask write not taken");
	rise_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
		(wr && addr == swk_pkg::RISE_MASK_OFS) |=> rise_mask_r == $past(wdata[GPIO_N-1:0]))
		else $error("rising mask write not taken");
	fall_write_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
		(wr && addr == swk_pkg::FALL_MASK_OFS) |=> fall_mask_r == $past(wdata[GPIO_N-1:0]))
		else $error("falling mask write not taken");
	gpio_summary_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
		status_view[swk_pkg::GPIO_BIT] == gpio_any)
		else $error("gpio summary does not follow flags");
	resv_zero_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
		status_view[7:4] == 4'h0)
		else $error("reserved status bits nonzero");
	rdata_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		!rd |=> rdata_r == 32'h0000_0000)
		else $error("read data outside its cycle");

	// wake request, oscillators and power state
	p3_timer_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
		(pstate_r == swk_pkg::SWK_P3 && !gpio_any && !status_r[swk_pkg::RESUME_BIT])
		|-> !wake_req)
		else $error("wake in suspend without gpio or resume");
	timer_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		(pstate_r != swk_pkg::SWK_P3 && status_r[swk_pkg::TIMER_BIT]
		&& !mask_r[swk_pkg::TIMER_BIT]) |-> wake_req)
		else $error("unmasked timer flag gave no wake");
	gpio_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE14
		(gpio_any && !mask_r[swk_pkg::GPIO_BIT]) |-> wake_req)
		else $error("unmasked gpio flag gave no wake");
	resume_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		(status_r[swk_pkg::RESUME_BIT] && !mask_r[swk_pkg::RESUME_BIT]) |-> wake_req)
		else $error("unmasked resume flag gave no wake");
	mask_block_a: assert property (@(posedge clk) disable iff (!nrst) // RULE11
		(mask_r[swk_pkg::TIMER_BIT] && mask_r[swk_pkg::GPIO_BIT]
		&& mask_r[swk_pkg::RESUME_BIT]) |-> !wake_req && !irq)
		else $error("masked sources still wake or interrupt");
	irq_source_a: assert property (@(posedge clk) disable iff (!nrst) // RULE18
		irq |-> any_unmasked)
		else $error("irq with no unmasked source");
	busy_no_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE8
		(busy && !any_unmasked) |-> !wake_req && !irq)
		else $error("busy raised wake or irq");
	osc_follow_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		(wake_req && pstate_r == swk_pkg::SWK_P3) |-> osc_restart)
		else $error("wake in suspend did not restart oscillators");
	osc_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
		(pstate_r == swk_pkg::SWK_P0 || pstate_r == swk_pkg::SWK_P1) |-> !osc_restart)
		else $error("oscillator restart while running");
	suspend_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE17
		(pstate_r == swk_pkg::SWK_P3 && wake_req) |=> pstate_r == swk_pkg::SWK_P1)
		else $error("wake in suspend did not go to p1");
	p2_wake_a: assert property (@(posedge clk) disable iff (!nrst) // RULE17
		(pstate_r == swk_pkg::SWK_P2 && wake_req) |=> pstate_r == swk_pkg::SWK_P1)
		else $error("wake in p2 did not go to p1");
	run_state_keep_a: assert property (@(posedge clk) disable iff (!nrst)
		(pstate_r == swk_pkg::SWK_P1 && !(wr && addr == swk_pkg::POWER_CTRL_OFS))
		|=> pstate_r == swk_pkg::SWK_P1)
		else $error("p1 left without a firmware request");

	// shutdown busy window
	busy_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		(shutdown_req && pstate_r == swk_pkg::SWK_P0) |=> busy [*8])
		else $error("busy dropped early");
	busy_count_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		(busy && !shutdown_req) |=> busy_cnt_r == $past(busy_cnt_r) - 16'h0001)
		else $error("busy counter did not step down");
	busy_idle_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
		(!busy && !shutdown_req) |=> !busy)
		else $error("busy rose without a shutdown request");
endmodule : swk_wake_src
